/* File: hw/iqh_engine.sv */
// Purpose: Interlocked insertion at the head of a self-relative queue
// Assumes: Memory port accepts one access per mem_req and mem_ready
// Notes:   Probe accesses test writability without changing memory
`timescale 1ns/1ps

// Operation
// - Header and entry addresses latched at start, before checks or access.
// - Interlock already set returns minus one, queue untouched.
// - Success returns one if queue was empty, else zero.
// - Checked: low three address bits nonzero gives illegal operand.
// - Checked: header equal to entry gives illegal operand.
// - Checked: address not sign-extended 32-bit gives illegal operand.
// - Locked read, test bit zero, conditional store with bit set, retry.
// - Retry budget exhausted returns minus one, queue untouched.
// - Checked: forward link bits 2:1 nonzero restore header, illegal operand.
// - Checked: unwritable entry or successor restores header, memory fault.
// - Write entry forward, entry back, successor back from displacement.
// - Barrier after lock and after link writes; last write frees header.
// - Resident: no alignment or memory checks before modification.
// - Operation runs to completion; interlock excludes other agents.
// - Checked reports all five exception kinds; resident only illegal operand.
// - Header bit zero is the secondary interlock, honoured by all.
module iqh_engine
(
    // Clock and reset
    input  wire logic                   clk,
    input  wire logic                   reset_n,
    // Request
    input  wire logic                   req_valid,
    output logic                        req_ready,
    input  wire logic                   req_resident,
    input  wire logic [63:0]            header_address_operand,
    input  wire logic [63:0]            entry_address_operand,
    // Completion
    output logic                        done_valid,
    output logic [63:0]                 status_result,
    output iqh_pkg::iqh_exc_t           exc_code,
    // Memory port
    output logic                        mem_req,
    input  wire logic                   mem_ready,
    output iqh_pkg::iqh_op_t            mem_op,
    output logic                        mem_probe,
    output logic [63:0]                 mem_addr,
    output logic [31:0]                 mem_wdata,
    input  wire logic                   mem_rvalid,
    input  wire logic [63:0]            mem_rdata,
    input  wire logic                   mem_cw_ok,
    input  wire logic                   mem_fault,
    input  wire iqh_pkg::iqh_exc_t      mem_fault_kind,
    output logic                        memory_barrier
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    iqh_pkg::iqh_state_t    state_q;
    logic [63:0]            hdr_q;
    logic [63:0]            ent_q;
    logic                   res_q;
    logic [63:0]            tmp0_q;
    logic [7:0]             retry_q;
    logic                   probe_ent_q;
    iqh_pkg::iqh_exc_t      pend_exc_q;
    logic                   wait_q;

    logic [63:0]            fwd;
    logic [63:0]            disp;
    logic                   bad_ops;
    logic                   acc;

    assign fwd  = iqh_pkg::iqh_sign_extend(tmp0_q);
    assign disp = iqh_pkg::iqh_sign_extend(hdr_q - ent_q);
    assign acc  = mem_req && mem_ready;
    // Operand checks for the checked variant
    assign bad_ops = (hdr_q[2:0] != 3'h0) || (ent_q[2:0] != 3'h0)
                  || (hdr_q == ent_q)
                  || (iqh_pkg::iqh_sign_extend(hdr_q) != hdr_q)
                  || (iqh_pkg::iqh_sign_extend(ent_q) != ent_q);

    assign req_ready = (state_q == iqh_pkg::IQH_IDLE);

    // ----------------------------------------------------------------
    // Operand capture
    // ----------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            hdr_q <= 64'h0;
            ent_q <= 64'h0;
            res_q <= 1'b0;
        end
        else if (req_valid && req_ready)
        begin
            hdr_q <= header_address_operand;
            ent_q <= entry_address_operand;
            res_q <= req_resident;
        end
    end

    // ----------------------------------------------------------------
    // Sequencer; no abort input exists once started
    // ----------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            state_q     <= iqh_pkg::IQH_IDLE;
            tmp0_q      <= 64'h0;
            retry_q     <= 8'h0;
            probe_ent_q <= 1'b0;
            pend_exc_q  <= iqh_pkg::IQH_EXC_NONE;
            wait_q      <= 1'b0;
            done_valid  <= 1'b0;
            status_result <= 64'h0;
            exc_code    <= iqh_pkg::IQH_EXC_NONE;
        end
        else
        begin
            done_valid <= 1'b0;
            unique case (state_q)
            iqh_pkg::IQH_IDLE:
                if (req_valid)
                begin
                    state_q    <= iqh_pkg::IQH_CHECK;
                    retry_q    <= iqh_pkg::RETRY_COUNT;
                    pend_exc_q <= iqh_pkg::IQH_EXC_NONE;
                    wait_q     <= 1'b0;
                end
            iqh_pkg::IQH_CHECK:
                if (!res_q && bad_ops)
                begin
                    exc_code   <= iqh_pkg::IQH_EXC_ILLOP;
                    status_result <= 64'h0;
                    state_q    <= iqh_pkg::IQH_DONE;
                end
                else
                    state_q <= iqh_pkg::IQH_LREAD;
            iqh_pkg::IQH_LREAD:
                if (acc)
                    wait_q <= 1'b1;
                else if (wait_q && mem_rvalid)
                begin
                    wait_q <= 1'b0;
                    tmp0_q <= mem_rdata;
                    if (mem_fault)
                    begin
                        exc_code <= res_q ? iqh_pkg::IQH_EXC_ILLOP
                                          : mem_fault_kind;
                        status_result <= 64'h0;
                        state_q  <= iqh_pkg::IQH_DONE;
                    end
                    else if (mem_rdata[0])
                    begin
                        status_result <= iqh_pkg::STATUS_BUSY;
                        exc_code <= iqh_pkg::IQH_EXC_NONE;
                        state_q  <= iqh_pkg::IQH_DONE;
                    end
                    else
                        state_q <= iqh_pkg::IQH_CSTORE;
                end
            iqh_pkg::IQH_CSTORE:
                if (acc)
                begin
                    retry_q <= retry_q - 8'h1;
                    if (mem_cw_ok)
                        state_q <= iqh_pkg::IQH_BAR1;
                    else if (retry_q == 8'h1)
                    begin
                        status_result <= iqh_pkg::STATUS_BUSY;
                        exc_code <= iqh_pkg::IQH_EXC_NONE;
                        state_q  <= iqh_pkg::IQH_DONE;
                    end
                    else
                        state_q <= iqh_pkg::IQH_LREAD;
                end
            iqh_pkg::IQH_BAR1:
                if (res_q)
                    state_q <= iqh_pkg::IQH_WFWD;
                else if (fwd[2:1] != 2'h0)
                begin
                    pend_exc_q <= iqh_pkg::IQH_EXC_ILLOP;
                    state_q    <= iqh_pkg::IQH_REL;
                end
                else
                begin
                    probe_ent_q <= 1'b1;
                    state_q     <= iqh_pkg::IQH_PROBE;
                end
            iqh_pkg::IQH_PROBE:
                if (acc)
                begin
                    if (mem_fault)
                    begin
                        pend_exc_q <= mem_fault_kind;
                        state_q    <= iqh_pkg::IQH_REL;
                    end
                    else if (probe_ent_q)
                        probe_ent_q <= 1'b0;
                    else
                        state_q <= iqh_pkg::IQH_WFWD;
                end
            iqh_pkg::IQH_WFWD:
                if (acc)
                    state_q <= iqh_pkg::IQH_WBACK;
            iqh_pkg::IQH_WBACK:
                if (acc)
                    state_q <= iqh_pkg::IQH_WSUCC;
            iqh_pkg::IQH_WSUCC:
                if (acc)
                    state_q <= iqh_pkg::IQH_BAR2;
            iqh_pkg::IQH_BAR2:
                state_q <= iqh_pkg::IQH_WHEAD;
            iqh_pkg::IQH_WHEAD:
                if (acc)
                begin
                    status_result <= (fwd == 64'h0)
                                   ? iqh_pkg::STATUS_EMPTY
                                   : iqh_pkg::STATUS_MORE;
                    exc_code <= iqh_pkg::IQH_EXC_NONE;
                    state_q  <= iqh_pkg::IQH_DONE;
                end
            iqh_pkg::IQH_REL:
                if (acc)
                begin
                    exc_code <= pend_exc_q;
                    status_result <= 64'h0;
                    state_q  <= iqh_pkg::IQH_DONE;
                end
            iqh_pkg::IQH_DONE:
            begin
                done_valid <= 1'b1;
                state_q    <= iqh_pkg::IQH_IDLE;
            end
            default:
                state_q <= iqh_pkg::IQH_IDLE;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Memory request decode
    // ----------------------------------------------------------------
    always_comb
    begin
        mem_req   = 1'b0;
        mem_op    = iqh_pkg::IQH_OP_WRITE;
        mem_probe = 1'b0;
        mem_addr  = hdr_q;
        mem_wdata = 32'h0;
        memory_barrier = (state_q == iqh_pkg::IQH_BAR1)
                      || (state_q == iqh_pkg::IQH_BAR2);
        unique case (state_q)
        iqh_pkg::IQH_LREAD:
        begin
            mem_req = !wait_q;
            mem_op  = iqh_pkg::IQH_OP_LREAD;
        end
        iqh_pkg::IQH_CSTORE:
        begin
            mem_req   = 1'b1;
            mem_op    = iqh_pkg::IQH_OP_CWRITE;
            mem_wdata = tmp0_q[31:0] | 32'h1;
        end
        iqh_pkg::IQH_PROBE:
        begin
            mem_req   = 1'b1;
            mem_probe = 1'b1;
            mem_addr  = probe_ent_q ? ent_q : hdr_q + fwd;
        end
        iqh_pkg::IQH_WFWD:
        begin
            mem_req   = 1'b1;
            mem_addr  = ent_q;
            mem_wdata = fwd[31:0] + disp[31:0];
        end
        iqh_pkg::IQH_WBACK:
        begin
            mem_req   = 1'b1;
            mem_addr  = ent_q + iqh_pkg::BACK_OFFSET;
            mem_wdata = disp[31:0];
        end
        iqh_pkg::IQH_WSUCC:
        begin
            mem_req   = 1'b1;
            mem_addr  = hdr_q + fwd + iqh_pkg::BACK_OFFSET;
            mem_wdata = 32'h0 - fwd[31:0] - disp[31:0];
        end
        iqh_pkg::IQH_WHEAD:
        begin
            mem_req   = 1'b1;
            mem_wdata = 32'h0 - disp[31:0];
        end
        iqh_pkg::IQH_REL:
        begin
            mem_req   = 1'b1;
            mem_wdata = tmp0_q[31:0];
        end
        default:
        begin
            mem_req = 1'b0;
        end
        endcase
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    property p_busy_status;
        @(posedge clk) disable iff (!reset_n)
        (state_q == iqh_pkg::IQH_LREAD && wait_q && mem_rvalid
         && mem_rdata[0] && !mem_fault)
        |=> ##1 (done_valid && status_result == iqh_pkg::STATUS_BUSY);
    endproperty
    a_busy_status: assert property (p_busy_status)
        else $error("busy header did not return minus one");

    property p_empty_status;
        @(posedge clk) disable iff (!reset_n)
        (state_q == iqh_pkg::IQH_WHEAD && acc)
        |=> (status_result == ((fwd == 64'h0) ? 64'h1 : 64'h0))
            ##1 done_valid;
    endproperty
    a_empty_status: assert property (p_empty_status)
        else $error("wrong success status");

    property p_illop_check;
        @(posedge clk) disable iff (!reset_n)
        (state_q == iqh_pkg::IQH_CHECK && !res_q && bad_ops)
        |=> ##1 (done_valid && exc_code == iqh_pkg::IQH_EXC_ILLOP);
    endproperty
    a_illop_check: assert property (p_illop_check)
        else $error("bad operands not refused");

    property p_same_addr;
        @(posedge clk) disable iff (!reset_n)
        (state_q == iqh_pkg::IQH_CHECK && !res_q && hdr_q == ent_q)
        |=> !mem_req [*2];
    endproperty
    a_same_addr: assert property (p_same_addr)
        else $error("access issued for equal addresses");

    property p_cwrite_bit;
        @(posedge clk) disable iff (!reset_n)
        (mem_req && mem_op == iqh_pkg::IQH_OP_CWRITE)
        |-> (mem_wdata[0] && mem_addr == hdr_q);
    endproperty
    a_cwrite_bit: assert property (p_cwrite_bit)
        else $error("conditional write lacks interlock bit");

    property p_retry_out;
        @(posedge clk) disable iff (!reset_n)
        (state_q == iqh_pkg::IQH_CSTORE && acc && !mem_cw_ok
         && retry_q == 8'h1)
        |=> ##1 (done_valid && status_result == iqh_pkg::STATUS_BUSY);
    endproperty
    a_retry_out: assert property (p_retry_out)
        else $error("exhausted retries not reported");

    property p_release;
        @(posedge clk) disable iff (!reset_n)
        (state_q == iqh_pkg::IQH_REL && mem_req)
        |-> (mem_wdata == tmp0_q[31:0] && mem_addr == hdr_q);
    endproperty
    a_release: assert property (p_release)
        else $error("release write wrong");

    property p_barrier_order;
        @(posedge clk) disable iff (!reset_n)
        (state_q == iqh_pkg::IQH_WSUCC && acc)
        |=> memory_barrier ##1 (mem_req && mem_wdata == -disp[31:0]);
    endproperty
    a_barrier_order: assert property (p_barrier_order)
        else $error("barrier or final header write missing");

    property p_resident_excs;
        @(posedge clk) disable iff (!reset_n)
        (done_valid && res_q)
        |-> (exc_code == iqh_pkg::IQH_EXC_NONE
             || exc_code == iqh_pkg::IQH_EXC_ILLOP);
    endproperty
    a_resident_excs: assert property (p_resident_excs)
        else $error("resident variant reported a memory fault");

    property p_one_done;
        @(posedge clk) disable iff (!reset_n)
        done_valid |=> !done_valid;
    endproperty
    a_one_done: assert property (p_one_done)
        else $error("completion held longer than one cycle");

    c_success: cover property (@(posedge clk) disable iff (!reset_n)
        state_q == iqh_pkg::IQH_WHEAD && acc);
    c_busy: cover property (@(posedge clk) disable iff (!reset_n)
        done_valid && status_result == iqh_pkg::STATUS_BUSY);
    c_release: cover property (@(posedge clk) disable iff (!reset_n)
        state_q == iqh_pkg::IQH_REL && acc);

endmodule

/* File: inc/iqh_pkg.sv */
// Purpose: Constants and types for the interlocked head insert engine
// Assumes: 64-bit addresses, 64-bit memory words, byte addressing
// Notes:   Status and exception encodings are local to this block
package iqh_pkg;

    localparam int          ADDR_W      = 64;
    localparam int          DATA_W      = 64;
    localparam int          RETRY_W     = 8;
    localparam logic [7:0]  RETRY_COUNT = 8'h10;
    localparam logic [63:0] BACK_OFFSET = 64'h0000_0000_0000_0004;
    localparam logic [63:0] STATUS_BUSY = 64'hFFFF_FFFF_FFFF_FFFF;
    localparam logic [63:0] STATUS_EMPTY = 64'h0000_0000_0000_0001;
    localparam logic [63:0] STATUS_MORE = 64'h0000_0000_0000_0000;

    typedef enum logic [2:0]
    {
        IQH_EXC_NONE    = 3'h0,
        IQH_EXC_ILLOP   = 3'h1,
        IQH_EXC_ACCVIO  = 3'h2,
        IQH_EXC_FOR     = 3'h3,
        IQH_EXC_FOW     = 3'h4,
        IQH_EXC_TNV     = 3'h5
    } iqh_exc_t;

    typedef enum logic [1:0]
    {
        IQH_OP_READ   = 2'h0,
        IQH_OP_LREAD  = 2'h1,
        IQH_OP_CWRITE = 2'h2,
        IQH_OP_WRITE  = 2'h3
    } iqh_op_t;

    typedef enum logic [3:0]
    {
        IQH_IDLE  = 4'h0,
        IQH_CHECK = 4'h1,
        IQH_LREAD = 4'h3,
        IQH_CSTORE = 4'h2,
        IQH_BAR1  = 4'h6,
        IQH_PROBE = 4'h7,
        IQH_WFWD  = 4'h5,
        IQH_WBACK = 4'h4,
        IQH_WSUCC = 4'hC,
        IQH_BAR2  = 4'hD,
        IQH_WHEAD = 4'hF,
        IQH_REL   = 4'hE,
        IQH_DONE  = 4'hA
    } iqh_state_t;

    // Sign extend the low 32 bits of a word
    function automatic logic [63:0] iqh_sign_extend(input logic [63:0] v);
        iqh_sign_extend = {{32{v[31]}}, v[31:0]};
    endfunction

endpackage

/* File: test/iqh_mem_model.sv */
// Purpose: Shared memory with locked read and conditional write
// Assumes: Longword storage keyed by byte address
// Notes:   Stall, store failures and probe faults are set by the bench
`timescale 1ns/1ps

module iqh_mem_model
(
    // Clock
    input  wire logic              clk,
    // Scenario controls
    input  wire logic              stall,
    input  wire logic [31:0]       cw_until,
    input  wire logic [63:0]       fault_addr,
    input  wire iqh_pkg::iqh_exc_t fault_kind,
    // Memory port
    input  wire logic              mem_req,
    output logic                   mem_ready,
    input  wire iqh_pkg::iqh_op_t  mem_op,
    input  wire logic              mem_probe,
    input  wire logic [63:0]       mem_addr,
    input  wire logic [31:0]       mem_wdata,
    output logic                   mem_rvalid,
    output logic [63:0]            mem_rdata,
    output logic                   mem_cw_ok,
    output logic                   mem_fault,
    output iqh_pkg::iqh_exc_t      mem_fault_kind,
    input  wire logic              memory_barrier
);
    logic [31:0] mem [logic [63:0]];
    logic        pend = 1'b0;
    logic        pf = 1'b0;
    logic [63:0] rd = 64'h0;
    int          n_acc = 0;
    int          n_cw = 0;
    int          n_wr = 0;
    int          n_bar = 0;

    initial
    begin
        mem_ready = 1'b0;
        mem_rvalid = 1'b0;
        mem_rdata = 64'h0;
        mem_cw_ok = 1'b0;
        mem_fault = 1'b0;
        mem_fault_kind = iqh_pkg::IQH_EXC_NONE;
    end

    function automatic logic [31:0] rd32(input logic [63:0] a);
        rd32 = mem.exists(a) ? mem[a] : 32'h0;
    endfunction

    // ----------------------------------------
    // Accesses taken on the rising edge
    // ----------------------------------------
    always @(posedge clk)
    begin
        n_bar += int'(memory_barrier);
        if (mem_req && mem_ready)
        begin
            n_acc++;
            if (mem_op == iqh_pkg::IQH_OP_LREAD)
            begin
                pend = 1'b1;
                pf = (mem_addr == fault_addr);
                rd = {rd32(mem_addr + 64'h4), rd32(mem_addr)};
            end
            if (mem_op == iqh_pkg::IQH_OP_CWRITE)
                n_cw++;
            if ((mem_op == iqh_pkg::IQH_OP_CWRITE && mem_cw_ok) ||
                (mem_op == iqh_pkg::IQH_OP_WRITE && !mem_probe))
            begin
                mem[mem_addr] = mem_wdata;
                n_wr++;
            end
        end
    end

    // ----------------------------------------
    // Answers driven on the falling edge
    // ----------------------------------------
    always @(negedge clk)
    begin
        mem_ready <= !stall || !mem_ready;
        mem_rvalid <= pend;
        mem_rdata <= pend ? rd : ~mem_rdata;
        mem_fault <= pend ? pf
                   : mem_req && mem_probe && mem_addr == fault_addr;
        pend = 1'b0;
        mem_cw_ok <= 32'(n_cw) >= cw_until;
        mem_fault_kind <= fault_kind;
    end

endmodule

/* File: test/tb_interlocked_queue_head_insert.sv */
// Purpose: Self-checking bench for the head insert engine
// Assumes: Memory model answers on the far side
// Notes:   Expected links are computed from header and entry addresses
`timescale 1ns/1ps

`define CHK(nm, ex, got) \
    begin \
        n_tests++; \
        if ((got) !== (ex)) \
        begin \
            err_total++; \
            $display("Error %s exp %h got %h", nm, ex, got); \
        end \
    end

module tb_interlocked_queue_head_insert;
    logic              clk, reset_n, req_valid, req_ready, req_resident;
    logic              done_valid, mem_req, mem_ready, mem_probe;
    logic              mem_rvalid, mem_cw_ok, mem_fault, memory_barrier;
    logic              stall;
    logic [63:0]       hdr, ent, status_result, mem_addr, mem_rdata;
    logic [63:0]       fault_addr;
    logic [31:0]       mem_wdata, cw_until;
    iqh_pkg::iqh_exc_t exc_code, mem_fault_kind, fault_kind;
    iqh_pkg::iqh_op_t  mem_op;
    int                err_total = 0;
    int                n_tests = 0;
    int                b_acc, b_cw, b_wr, b_bar;

    iqh_engine i_dut (.clk(clk), .reset_n(reset_n), .req_valid(req_valid),
        .req_ready(req_ready), .req_resident(req_resident),
        .header_address_operand(hdr), .entry_address_operand(ent),
        .done_valid(done_valid), .status_result(status_result),
        .exc_code(exc_code), .mem_req(mem_req), .mem_ready(mem_ready),
        .mem_op(mem_op), .mem_probe(mem_probe), .mem_addr(mem_addr),
        .mem_wdata(mem_wdata), .mem_rvalid(mem_rvalid),
        .mem_rdata(mem_rdata), .mem_cw_ok(mem_cw_ok), .mem_fault(mem_fault),
        .mem_fault_kind(mem_fault_kind), .memory_barrier(memory_barrier));

    iqh_mem_model i_mem (.clk(clk), .stall(stall), .cw_until(cw_until),
        .fault_addr(fault_addr), .fault_kind(fault_kind), .mem_req(mem_req),
        .mem_ready(mem_ready), .mem_op(mem_op), .mem_probe(mem_probe),
        .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rvalid(mem_rvalid),
        .mem_rdata(mem_rdata), .mem_cw_ok(mem_cw_ok), .mem_fault(mem_fault),
        .mem_fault_kind(mem_fault_kind), .memory_barrier(memory_barrier));

    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic stop_test();
        if (err_total == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic snap();
        b_acc = i_mem.n_acc;
        b_cw = i_mem.n_cw;
        b_wr = i_mem.n_wr;
        b_bar = i_mem.n_bar;
    endtask

    task automatic run(input logic res, input logic [63:0] h, e);
        int k;
        k = 0;
        @(negedge clk);
        req_valid = 1'b1;
        req_resident = res;
        hdr = h;
        ent = e;
        @(negedge clk);
        req_valid = 1'b0;
        hdr = ~h;
        ent = ~e;
        `CHK("ready_busy", 1'b0, req_ready)
        while (done_valid !== 1'b1)
        begin
            @(posedge clk);
            #1;
            k++;
            if (k > 400)
            begin
                err_total++;
                stop_test();
            end
        end
        @(posedge clk);
        #1;
        `CHK("done_once", 1'b0, done_valid)
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic ins(input logic res, input logic [63:0] h, e,
                       input int fails);
        logic [31:0] f, d;
        logic [63:0] s;
        f = i_mem.mem[h];
        d = h[31:0] - e[31:0];
        s = h + {{32{f[31]}}, f} + 64'h4;
        cw_until = 32'(i_mem.n_cw + fails);
        snap();
        run(res, h, e);
        `CHK("status", (f == 32'h0) ? iqh_pkg::STATUS_EMPTY
            : iqh_pkg::STATUS_MORE, status_result)
        `CHK("exc", iqh_pkg::IQH_EXC_NONE, exc_code)
        `CHK("ent_fwd", f + d, i_mem.mem[e])
        `CHK("ent_back", d, i_mem.mem[e + 64'h4])
        `CHK("succ_back", 32'h0 - f - d, i_mem.mem[s])
        `CHK("hdr_fwd", 32'h0 - d, i_mem.mem[h])
        `CHK("barriers", b_bar + 2, i_mem.n_bar)
        `CHK("cw_tries", b_cw + fails + 1, i_mem.n_cw)
        `CHK("writes", b_wr + 5, i_mem.n_wr)
    endtask

    task automatic t_nolock();
        i_mem.mem[64'h1000] = 32'h0000_2001;
        snap();
        run(1'b0, 64'h1000, 64'h5000);
        `CHK("busy", iqh_pkg::STATUS_BUSY, status_result)
        `CHK("busy_hdr", 32'h0000_2001, i_mem.mem[64'h1000])
        `CHK("busy_wr", b_wr, i_mem.n_wr)
        i_mem.mem[64'h1000] = 32'h0000_2000;
        cw_until = 32'(i_mem.n_cw + 1000);
        snap();
        run(1'b0, 64'h1000, 64'h5000);
        `CHK("retry", iqh_pkg::STATUS_BUSY, status_result)
        `CHK("tries", b_cw + int'(iqh_pkg::RETRY_COUNT), i_mem.n_cw)
        `CHK("retry_wr", b_wr, i_mem.n_wr)
        cw_until = 32'h0;
    endtask

    task automatic t_illegal();
        logic [63:0] hs [6] = '{64'h1004, 64'h1000, 64'h1000,
            64'h1_0000_1000, 64'h1000, 64'h8000_1000};
        logic [63:0] es [6] = '{64'h3000, 64'h3002, 64'h1000,
            64'h3000, 64'hFFFF_FFFF_0000_3000, 64'h3000};
        for (int i = 0; i < 6; i++)
        begin
            snap();
            run(1'b0, hs[i], es[i]);
            `CHK("illop", iqh_pkg::IQH_EXC_ILLOP, exc_code)
            `CHK("no_access", b_acc, i_mem.n_acc)
        end
    endtask

    task automatic t_faults();
        logic [31:0]       f;
        iqh_pkg::iqh_exc_t ks [4] = '{iqh_pkg::IQH_EXC_ACCVIO,
            iqh_pkg::IQH_EXC_FOR, iqh_pkg::IQH_EXC_FOW, iqh_pkg::IQH_EXC_TNV};
        f = i_mem.mem[64'h1000];
        i_mem.mem[64'h1000] = 32'h0000_0006;
        run(1'b0, 64'h1000, 64'h5000);
        `CHK("link_illop", iqh_pkg::IQH_EXC_ILLOP, exc_code)
        `CHK("link_hdr", 32'h0000_0006, i_mem.mem[64'h1000])
        i_mem.mem[64'h1000] = f;
        for (int i = 0; i < 4; i++)
        begin
            fault_addr = i[0] ? 64'h1000 + {{32{f[31]}}, f} : 64'h5000;
            fault_kind = ks[i];
            snap();
            run(1'b0, 64'h1000, 64'h5000);
            `CHK("fault_kind", ks[i], exc_code)
            `CHK("fault_hdr", f, i_mem.mem[64'h1000])
            `CHK("fault_wr", b_wr + 2, i_mem.n_wr)
        end
        fault_addr = 64'h1000;
        for (int i = 0; i < 2; i++)
        begin
            snap();
            run(i[0], 64'h1000, 64'h5000);
            `CHK("rd_exc", i[0] ? iqh_pkg::IQH_EXC_ILLOP : ks[3],
                exc_code)
            `CHK("rd_status", 64'h0, status_result)
            `CHK("rd_hdr", f, i_mem.mem[64'h1000])
            `CHK("rd_wr", b_wr, i_mem.n_wr)
        end
        fault_addr = 64'hFFF8;
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        reset_n = 1'b0;
        req_valid = 1'b0;
        req_resident = 1'b0;
        hdr = 64'h0;
        ent = 64'h0;
        stall = 1'b0;
        cw_until = 32'h0;
        fault_addr = 64'hFFF8;
        fault_kind = iqh_pkg::IQH_EXC_NONE;
        i_mem.mem[64'h1000] = 32'h0;
        i_mem.mem[64'h1004] = 32'h0;
        repeat (3) @(posedge clk);
        @(negedge clk);
        reset_n = 1'b1;
        ins(1'b0, 64'h1000, 64'h2000, 0);
        stall = 1'b1;
        ins(1'b1, 64'h1000, 64'h3000, 2);
        stall = 1'b0;
        ins(1'b0, 64'h1000, 64'hFFFF_FFFF_8000_0000, 0);
        t_nolock();
        t_illegal();
        t_faults();
        stop_test();
    end

endmodule
